// [hdl/ifetch_pkg.sv]
// Shared constants and carrier types for the instruction fetch and issue front end
package ifetch_pkg;

  // ==========================================================================
  // Sizes
  localparam int PARCEL_W = 16;
  localparam int ADDR_W = 32;
  localparam int BUF_COUNT = 4;
  localparam int BUF_PARCELS = 128;
  localparam int TOTAL_PARCELS = BUF_COUNT * BUF_PARCELS;
  localparam int OFF_W = 7;
  localparam int SEL_W = 2;
  localparam int TAG_W = ADDR_W - OFF_W;
  localparam int FIFO_DEPTH = 32;
  localparam int UNIT_W = 3;
  localparam int UNIT_COUNT = 8;

  // ==========================================================================
  // Reset values and counts
  localparam logic [ADDR_W-1:0] PC_RESET = 32'h0;
  localparam logic [OFF_W-1:0] LAST_OFFSET = 7'h7f;
  localparam logic [OFF_W-1:0] OFFSET_ZERO = 7'h0;
  localparam logic [SEL_W-1:0] FILL_PTR_RESET = 2'h0;

  // ==========================================================================
  // Parcel field layout
  localparam int LEN_MSB = 15;
  localparam int LEN_LSB = 14;
  localparam int UNIT_MSB = 13;
  localparam int UNIT_LSB = 11;
  localparam logic [1:0] LEN_CODE_TWO = 2'h2;
  localparam logic [1:0] LEN_CODE_THREE = 2'h3;
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ==========================================================================
  // Types
  typedef logic [PARCEL_W-1:0] parcel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } fetch_req_t;

  typedef struct packed {
    parcel_t first;
    parcel_t second;
    parcel_t third;
    logic [1:0] length;
    logic [UNIT_W-1:0] unit;
  } instr_t;

  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_REQUEST,
    FETCH_FILL,
    FETCH_ERROR
  } fetch_state_t;

endpackage

// [hdl/parcel_fifo.sv]
// Parameterised valid/ready FIFO for parcels returning from central memory
`timescale 1ns/1ns
`default_nettype none
module parcel_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W:0] wr;
    logic [PTR_W:0] rd;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;

  // ==========================================================================
  // Pointers carry one extra bit so full and empty differ
  always_comb begin
    full = (st.wr[PTR_W] != st.rd[PTR_W]) && (st.wr[PTR_W-1:0] == st.rd[PTR_W-1:0]);
    empty = st.wr == st.rd;
    in_ready = !full;
    out_valid = !empty;
    out_data = mem[st.rd[PTR_W-1:0]];
    next_st = st;
    if (in_valid && !full) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem[st.wr[PTR_W-1:0]] <= in_data;
    end
  end

endmodule
`default_nettype wire

// [hdl/parcel_decode.sv]
// Early decode of a parcel: instruction length and needed functional unit
`timescale 1ns/1ns
`default_nettype none
module parcel_decode (
  input wire ifetch_pkg::parcel_t parcel,
  output logic [1:0] length,
  output logic [ifetch_pkg::UNIT_W-1:0] unit
);

  // ==========================================================================
  // Length code in the top bits, unit selector below it
  always_comb begin
    unit = parcel[ifetch_pkg::UNIT_MSB:ifetch_pkg::UNIT_LSB];
    case (parcel[ifetch_pkg::LEN_MSB:ifetch_pkg::LEN_LSB])
      ifetch_pkg::LEN_CODE_THREE: length = ifetch_pkg::LEN_THREE;
      ifetch_pkg::LEN_CODE_TWO: length = ifetch_pkg::LEN_TWO;
      default: length = ifetch_pkg::LEN_ONE;
    endcase
  end

endmodule
`default_nettype wire

// [hdl/instruction_fetch_issue.sv]
// Instruction fetch into four circular buffers and parcel staging to issue
//
// Contract
// - Four buffers of 128 consecutive parcels each, 512 in all.
// - Counter pointing outside every buffer starts a fetch from memory.
// - An exchange always forces a fresh fetch afterwards.
// - Buffers fill in circular order, one 128-parcel block per fetch.
// - The fifth fetch overwrites the first buffer again.
// - Counter selects one buffered parcel, loaded into the next holder.
// - Counter steps as parcels move on; branch or exchange reload it.
// - Next holder stages a parcel before current holder; decode starts there.
// - Current holder keeps the waiting instruction until it issues.
// - Two-parcel instruction: current holds first, second holder second.
// - Three-parcel instruction: current, second, third holders in order.
// - Issue only once every unit the instruction needs is free.
// - Fetch and issue are segmented, one step per clock.
// - Fetch address is the parcel counter's block start (offset zero) plus the code base.
// - Fetch address above the code limit sets the range error flag.
`timescale 1ns/1ns
`default_nettype none
module instruction_fetch_issue (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [ifetch_pkg::ADDR_W-1:0] code_base,
  input wire logic [ifetch_pkg::ADDR_W-1:0] code_limit,
  input wire logic exchange_valid,
  input wire logic [ifetch_pkg::ADDR_W-1:0] exchange_pc,
  input wire logic branch_valid,
  input wire logic [ifetch_pkg::ADDR_W-1:0] branch_pc,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output ifetch_pkg::fetch_req_t mem_req,
  input wire logic mem_rsp_valid,
  output logic mem_rsp_ready,
  input wire ifetch_pkg::parcel_t mem_rsp_parcel,
  input wire logic [ifetch_pkg::UNIT_COUNT-1:0] unit_busy,
  output logic issue_valid,
  output ifetch_pkg::instr_t issue_instr,
  output logic program_range_error,
  input wire logic range_error_clear
);

  // ==========================================================================
  // State
  typedef struct packed {
    ifetch_pkg::fetch_state_t fsm;
    logic [ifetch_pkg::ADDR_W-1:0] pc;
    logic [ifetch_pkg::BUF_COUNT-1:0] buf_valid;
    logic [ifetch_pkg::BUF_COUNT-1:0][ifetch_pkg::TAG_W-1:0] buf_tag;
    logic [ifetch_pkg::SEL_W-1:0] fill_ptr;
    logic [ifetch_pkg::TAG_W-1:0] fill_tag;
    logic [ifetch_pkg::OFF_W-1:0] fill_count;
    logic fill_discard;
    logic [ifetch_pkg::ADDR_W-1:0] req_addr;
    logic range_error;
    logic nxt_valid;
    ifetch_pkg::parcel_t nxt;
    logic [1:0] held;
    ifetch_pkg::instr_t group;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  // Buffer storage; no reset, validity lives in buf_valid
  ifetch_pkg::parcel_t ibuf [ifetch_pkg::TOTAL_PARCELS];

  // ==========================================================================
  // Buffer lookup
  function automatic logic [ifetch_pkg::SEL_W:0] lookup(
    input logic [ifetch_pkg::BUF_COUNT-1:0] valid,
    input logic [ifetch_pkg::BUF_COUNT-1:0][ifetch_pkg::TAG_W-1:0] tags,
    input logic [ifetch_pkg::TAG_W-1:0] tag
  );
    logic [ifetch_pkg::SEL_W:0] found;
    found = '0;
    for (int i = 0; i < ifetch_pkg::BUF_COUNT; i++) begin
      if (valid[i] && tags[i] == tag) begin
        found = {1'b1, i[ifetch_pkg::SEL_W-1:0]};
      end
    end
    return found;
  endfunction

  // Block number of a parcel address; buffers are matched and filled by it
  function automatic logic [ifetch_pkg::TAG_W-1:0] block_tag(
    input logic [ifetch_pkg::ADDR_W-1:0] addr
  );
    return addr[ifetch_pkg::ADDR_W-1:ifetch_pkg::OFF_W];
  endfunction

  logic [ifetch_pkg::SEL_W:0] found;
  logic hit;
  logic [ifetch_pkg::SEL_W-1:0] hit_buf;
  ifetch_pkg::parcel_t read_parcel;
  logic [ifetch_pkg::ADDR_W-1:0] fetch_addr;
  logic redirect;
  logic [ifetch_pkg::ADDR_W-1:0] redirect_pc;

  always_comb begin
    found = lookup(st.buf_valid, st.buf_tag, block_tag(st.pc));
    hit = found[ifetch_pkg::SEL_W];
    hit_buf = found[ifetch_pkg::SEL_W-1:0];
    read_parcel = ibuf[{hit_buf, st.pc[ifetch_pkg::OFF_W-1:0]}];
    // Whole block is fetched, so the address starts at offset zero
    fetch_addr = code_base + {block_tag(st.pc), ifetch_pkg::OFFSET_ZERO};
    redirect = exchange_valid || branch_valid;
    redirect_pc = exchange_valid ? exchange_pc : branch_pc;
  end

  // ==========================================================================
  // Return path buffering
  logic fifo_out_valid;
  logic fifo_out_ready;
  ifetch_pkg::parcel_t fifo_out_data;
  logic buf_we;
  logic [ifetch_pkg::SEL_W+ifetch_pkg::OFF_W-1:0] buf_waddr;

  parcel_fifo #(
    .WIDTH(ifetch_pkg::PARCEL_W),
    .DEPTH(ifetch_pkg::FIFO_DEPTH)
  ) u_return_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(mem_rsp_valid),
    .in_ready(mem_rsp_ready),
    .in_data(mem_rsp_parcel),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Parcels drain only while a fill is open; otherwise they wait in the FIFO and memory stalls once it is full
  always_comb begin
    fifo_out_ready = st.fsm == ifetch_pkg::FETCH_FILL;
    buf_we = fifo_out_valid && fifo_out_ready && !st.fill_discard;
    buf_waddr = {st.fill_ptr, st.fill_count};
  end

  always_ff @(posedge sys_clk) begin
    if (buf_we) begin
      ibuf[buf_waddr] <= fifo_out_data;
    end
  end

  // ==========================================================================
  // Early decode in the next holder
  logic [1:0] nxt_len;
  logic [ifetch_pkg::UNIT_W-1:0] nxt_unit;

  parcel_decode u_decode (
    .parcel(st.nxt),
    .length(nxt_len),
    .unit(nxt_unit)
  );

  // ==========================================================================
  // Next-state logic
  logic group_done;
  logic issue_fire;
  logic [1:0] eff_held;
  logic room;
  logic move;
  logic nxt_free;
  logic range_set;

  // Limitation: a branch into a block that is still filling waits for the
  // whole block, since buffers only become usable after all 128 parcels.
  // This keeps the hit logic to a tag compare at the cost of some latency.
  always_comb begin
    next_st = st;
    range_set = 1'b0;

    // Issue stage
    group_done = st.held != ifetch_pkg::LEN_NONE && st.held == st.group.length;
    issue_fire = group_done && !unit_busy[st.group.unit];
    if (issue_fire) begin
      next_st.held = ifetch_pkg::LEN_NONE;
    end
    eff_held = issue_fire ? ifetch_pkg::LEN_NONE : st.held;
    // A waiting, complete instruction blocks the holders behind it
    room = eff_held == ifetch_pkg::LEN_NONE || eff_held < st.group.length;
    move = st.nxt_valid && room;

    if (move) begin
      case (eff_held)
        ifetch_pkg::LEN_NONE: begin
          next_st.group.first = st.nxt;
          next_st.group.length = nxt_len;
          next_st.group.unit = nxt_unit;
          next_st.held = ifetch_pkg::LEN_ONE;
        end

        ifetch_pkg::LEN_ONE: begin
          next_st.group.second = st.nxt;
          next_st.held = ifetch_pkg::LEN_TWO;
        end

        default: begin
          next_st.group.third = st.nxt;
          next_st.held = ifetch_pkg::LEN_THREE;
        end
      endcase
    end

    // Next holder load, one parcel per clock at most
    nxt_free = !st.nxt_valid || move;
    if (nxt_free) begin
      if (hit) begin
        next_st.nxt = read_parcel;
        next_st.nxt_valid = 1'b1;
        next_st.pc = st.pc + 32'h1;
      end else begin
        next_st.nxt_valid = 1'b0;
      end
    end

    // Fetch sequencer
    case (st.fsm)
      ifetch_pkg::FETCH_IDLE: begin
        if (!hit && !redirect) begin
          if (fetch_addr > code_limit) begin
            range_set = 1'b1;
            next_st.range_error = 1'b1;
            next_st.fsm = ifetch_pkg::FETCH_ERROR;
          end else begin
            next_st.req_addr = fetch_addr;
            next_st.fill_tag = block_tag(st.pc);
            next_st.buf_valid[st.fill_ptr] = 1'b0;
            next_st.fill_count = ifetch_pkg::OFFSET_ZERO;
            next_st.fsm = ifetch_pkg::FETCH_REQUEST;
          end
        end
      end

      // Request stands until memory takes it
      ifetch_pkg::FETCH_REQUEST: begin
        if (mem_req_ready) begin
          next_st.fsm = ifetch_pkg::FETCH_FILL;
        end
      end

      // One parcel drained from the return FIFO per clock
      ifetch_pkg::FETCH_FILL: begin
        if (fifo_out_valid) begin
          next_st.fill_count = st.fill_count + 7'h1;
          if (st.fill_count == ifetch_pkg::LAST_OFFSET) begin
            next_st.fsm = ifetch_pkg::FETCH_IDLE;
            next_st.fill_discard = 1'b0;
            if (!st.fill_discard) begin
              next_st.buf_valid[st.fill_ptr] = 1'b1;
              next_st.buf_tag[st.fill_ptr] = st.fill_tag;
              // Two-bit pointer wraps, so the fifth fill lands in buffer 0
              next_st.fill_ptr = st.fill_ptr + 2'h1;
            end
          end
        end
      end

      ifetch_pkg::FETCH_ERROR: begin
        // Waits for software to move the counter elsewhere
        if (redirect) begin
          next_st.fsm = ifetch_pkg::FETCH_IDLE;
        end
      end

      default: begin
        next_st.fsm = ifetch_pkg::FETCH_IDLE;
      end
    endcase


    // Redirect flushes the staging holders
    if (redirect) begin
      next_st.pc = redirect_pc;
      next_st.nxt_valid = 1'b0;
      next_st.held = ifetch_pkg::LEN_NONE;
    end
    // Exchange drops every buffer so a fetch must follow; an open fill
    // still drains its parcels but they are thrown away
    if (exchange_valid) begin
      next_st.buf_valid = '0;
      if (next_st.fsm == ifetch_pkg::FETCH_REQUEST ||
          next_st.fsm == ifetch_pkg::FETCH_FILL) begin
        next_st.fill_discard = 1'b1;
      end
    end


    // Set wins over a clear arriving in the same clock, so a new range
    // fault is never lost to a clear meant for the previous one
    if (range_error_clear && !range_set) begin
      next_st.range_error = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.fsm <= ifetch_pkg::FETCH_IDLE;
      st.pc <= ifetch_pkg::PC_RESET;
      st.fill_ptr <= ifetch_pkg::FILL_PTR_RESET;
      st.held <= ifetch_pkg::LEN_NONE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // Issue has no ready of its own: a free unit is the permission, so
  // issue_valid is combinational and the instruction leaves on that edge.
  always_comb begin
    // Request and its address come straight from registered state
    mem_req_valid = st.fsm == ifetch_pkg::FETCH_REQUEST;
    mem_req.addr = st.req_addr;
    issue_valid = group_done && !unit_busy[st.group.unit];
    issue_instr = st.group;
    program_range_error = st.range_error;
  end

endmodule
`default_nettype wire

// [tb/tb_pattern_pkg.sv]
// Parcel contents that the memory model serves and the bench expects
`default_nettype none
package tb_pattern_pkg;

  // ==========================================================================
  // Eight-parcel repeat: 1, 2, 1, 3, 1 parcel instructions, units walk upward
  function automatic logic [15:0] parcel_of(input logic [31:0] a);
    logic [1:0] code;
    code = (a[2:0] == 3'h1) ? 2'h2 : (a[2:0] == 3'h4) ? 2'h3 : 2'h0;
    return {code, a[5:3], a[10:0]};
  endfunction

endpackage
`default_nettype wire

// [tb/ifetch_mem_model.sv]
// Central memory model: takes one block request, returns 128 parcels in order
`timescale 1ns/1ns
`default_nettype none
module ifetch_mem_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire ifetch_pkg::fetch_req_t mem_req,
  output logic mem_rsp_valid,
  input wire logic mem_rsp_ready,
  output ifetch_pkg::parcel_t mem_rsp_parcel
);
  logic busy;
  logic take;
  logic [7:0] idx;
  logic [7:0] nidx;
  logic [31:0] base;
  ifetch_pkg::parcel_t last;

  // ==========================================================================
  // Handshake
  assign take = mem_rsp_valid && mem_rsp_ready;
  assign nidx = idx + {7'h0, take};
  assign mem_req_ready = !busy && !stall;
  // Idle data lines flip so a stale parcel never looks valid
  assign mem_rsp_parcel = mem_rsp_valid ? tb_pattern_pkg::parcel_of(base + {24'h0, idx}) : ~last;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      idx <= 8'h0;
      base <= 32'h0;
      last <= 16'h0;
      mem_rsp_valid <= 1'b0;
    end else begin
      if (mem_rsp_valid) begin
        last <= mem_rsp_parcel;
      end
      if (mem_req_valid && mem_req_ready) begin
        busy <= 1'b1;
        idx <= 8'h0;
        base <= mem_req.addr;
      end else if (busy) begin
        idx <= nidx;
        if (!mem_rsp_valid || take) begin
          mem_rsp_valid <= !stall && (nidx < 8'h80);
        end
        if (nidx == 8'h80) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb/ifetch_issue_asserts.sv]
// Port-level assertions for the instruction fetch and issue front end
`timescale 1ns/1ns
`default_nettype none
module ifetch_issue_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [ifetch_pkg::ADDR_W-1:0] code_base,
  input wire logic [ifetch_pkg::ADDR_W-1:0] code_limit,
  input wire logic exchange_valid,
  input wire logic branch_valid,
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire ifetch_pkg::fetch_req_t mem_req,
  input wire logic [ifetch_pkg::UNIT_COUNT-1:0] unit_busy,
  input wire logic issue_valid,
  input wire ifetch_pkg::instr_t issue_instr,
  input wire logic program_range_error,
  input wire logic range_error_clear
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Sequences
  sequence s_redirect;
    branch_valid || exchange_valid;
  endsequence
  sequence s_req_taken;
    mem_req_valid && mem_req_ready;
  endsequence

  // ==========================================================================
  // Properties
  property p_issue_free;
    issue_valid |-> !unit_busy[issue_instr.unit];
  endproperty
  a_issue_free: assert property (p_issue_free) else $error("issue to a busy unit");
  property p_req_stable;
    mem_req_valid && !mem_req_ready && !branch_valid && !exchange_valid
      |=> mem_req_valid && $stable(mem_req.addr);
  endproperty
  a_req_stable: assert property (p_req_stable) else $error("request dropped");
  property p_req_block;
    mem_req_valid |-> ((mem_req.addr - code_base) & 32'h7f) == 32'h0;
  endproperty
  a_req_block: assert property (p_req_block) else $error("fetch not block aligned");
  property p_req_limit;
    mem_req_valid |-> mem_req.addr <= code_limit;
  endproperty
  a_req_limit: assert property (p_req_limit) else $error("fetch above limit");
  property p_len_decode;
    issue_valid |-> issue_instr.length == ((issue_instr.first[15:14] == 2'h3) ?
      ifetch_pkg::LEN_THREE : (issue_instr.first[15:14] == 2'h2) ?
      ifetch_pkg::LEN_TWO : ifetch_pkg::LEN_ONE);
  endproperty
  a_len_decode: assert property (p_len_decode) else $error("length wrong");
  property p_unit_decode;
    issue_valid |-> issue_instr.unit == issue_instr.first[13:11];
  endproperty
  a_unit_decode: assert property (p_unit_decode) else $error("unit wrong");
  property p_flush;
    s_redirect |=> !issue_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("issue after redirect");
  property p_exch_fetch;
    exchange_valid |-> ##[1:1000] mem_req_valid;
  endproperty
  a_exch_fetch: assert property (p_exch_fetch) else $error("no fetch after exchange");
  // A block is 128 beats, so no second request can follow within 8 cycles
  property p_one_req;
    s_req_taken |=> !mem_req_valid [*8];
  endproperty
  a_one_req: assert property (p_one_req) else $error("overlapping requests");
  property p_flag_hold;
    program_range_error && !range_error_clear |=> program_range_error;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("range flag lost");
endmodule

bind instruction_fetch_issue ifetch_issue_asserts chk (
  .sys_clk, .sys_rst, .code_base, .code_limit, .exchange_valid, .branch_valid,
  .mem_req_valid, .mem_req_ready, .mem_req, .unit_busy, .issue_valid, .issue_instr,
  .program_range_error, .range_error_clear
);
`default_nettype wire

// [tb/tb_instruction_fetch_issue.sv]
// Self-checking bench for the instruction fetch and issue front end
`timescale 1ns/1ns
`default_nettype none
module tb_instruction_fetch_issue;
  logic sys_clk;
  logic sys_rst;
  logic [31:0] code_base, code_limit, exchange_pc, branch_pc, exp_pc, exp_blk;
  logic exchange_valid, branch_valid, mem_req_valid, mem_req_ready, mem_rsp_valid;
  logic mem_rsp_ready, issue_valid, program_range_error, range_error_clear, stall, hold_all;
  logic [7:0] unit_busy = 8'hff;
  ifetch_pkg::fetch_req_t mem_req;
  ifetch_pkg::parcel_t mem_rsp_parcel, p;
  ifetch_pkg::instr_t issue_instr;
  integer seed, failures, num_checks, num_req, cycles, n0;

  instruction_fetch_issue dut (
    .sys_clk, .sys_rst, .code_base, .code_limit, .exchange_valid, .exchange_pc,
    .branch_valid, .branch_pc, .mem_req_valid, .mem_req_ready, .mem_req, .mem_rsp_valid,
    .mem_rsp_ready, .mem_rsp_parcel, .unit_busy, .issue_valid, .issue_instr,
    .program_range_error, .range_error_clear
  );
  ifetch_mem_model mem (
    .sys_clk, .sys_rst, .stall, .mem_req_valid, .mem_req_ready, .mem_req,
    .mem_rsp_valid, .mem_rsp_ready, .mem_rsp_parcel
  );

  // ==========================================================================
  // Helpers
  task check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [1:0] exp_len(input ifetch_pkg::parcel_t q);
    return (q[15:14] == 2'h3) ? ifetch_pkg::LEN_THREE :
      (q[15:14] == 2'h2) ? ifetch_pkg::LEN_TWO : ifetch_pkg::LEN_ONE;
  endfunction
  task conclude();
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task run_to(input logic [31:0] t);
    repeat (20000) if (exp_pc < t) @(posedge sys_clk);
  endtask
  // All units busy around the redirect edge so no issue races the flush
  task redirect(input logic exch, input logic [31:0] pc);
    hold_all <= 1'b1;
    repeat (3) @(posedge sys_clk);
    exchange_valid <= exch;
    exchange_pc <= pc;
    branch_valid <= !exch;
    branch_pc <= pc;
    @(posedge sys_clk);
    exchange_valid <= 1'b0;
    branch_valid <= 1'b0;
    exp_pc = pc;
    exp_blk = pc >> 7;
    hold_all <= 1'b0;
  endtask

  // ==========================================================================
  // Clock, random drive and monitors
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    unit_busy <= hold_all ? 8'hff : 8'($random(seed) & $random(seed));
    stall <= ($random(seed) & 32'h3) == 32'h0;
    if (cycles == 32'hea60) begin
      failures++;
      conclude();
    end
  end
  always @(posedge sys_clk) begin
    if (!sys_rst && issue_valid === 1'b1) begin
      p = tb_pattern_pkg::parcel_of(code_base + exp_pc);
      check("first", p, issue_instr.first);
      check("length", exp_len(p), issue_instr.length);
      check("unit", p[13:11], issue_instr.unit);
      if (exp_len(p) != ifetch_pkg::LEN_ONE) begin
        check("second", tb_pattern_pkg::parcel_of(code_base + exp_pc + 1), issue_instr.second);
      end
      if (exp_len(p) == ifetch_pkg::LEN_THREE) begin
        check("third", tb_pattern_pkg::parcel_of(code_base + exp_pc + 2), issue_instr.third);
      end
      exp_pc = exp_pc + exp_len(p);
    end
    if (!sys_rst && mem_req_valid === 1'b1 && mem_req_ready === 1'b1) begin
      num_req++;
      check("fetch_addr", code_base + (exp_blk << 7), mem_req.addr);
      exp_blk = exp_blk + 1;
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    seed = 47;
    failures = 0;
    num_checks = 0;
    num_req = 0;
    cycles = 0;
    sys_rst = 1'b1;
    code_base = 32'h3a40;
    code_limit = 32'hffffffff;
    exchange_valid = 1'b0;
    exchange_pc = 32'h0;
    branch_valid = 1'b0;
    branch_pc = 32'h0;
    range_error_clear = 1'b0;
    stall = 1'b0;
    hold_all = 1'b0;
    exp_pc = 32'h0;
    exp_blk = 32'h0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    run_to(32'h2bc);
    check("fetch_count", 64'h6, num_req);
    n0 = num_req;
    redirect(1'b0, 32'h180);
    run_to(32'h1a0);
    check("hit_fetches", n0, num_req);
    redirect(1'b0, 32'h0);
    run_to(32'h28);
    check("wrap_fetches", n0 + 1, num_req);
    redirect(1'b1, 32'h10);
    run_to(32'h30);
    check("exchange_fetches", n0 + 2, num_req);
    code_limit <= code_base + 32'h7ff;
    redirect(1'b0, 32'h800);
    repeat (6) @(posedge sys_clk);
    check("range_flag", 64'h1, program_range_error);
    check("range_fetches", n0 + 2, num_req);
    range_error_clear <= 1'b1;
    @(posedge sys_clk);
    range_error_clear <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("range_clear", 64'h0, program_range_error);
    code_limit <= 32'hffffffff;
    redirect(1'b1, 32'h0);
    run_to(32'h12c);
    check("resume_fetches", n0 + 5, num_req);
    conclude();
  end
endmodule
`default_nettype wire
